// >>> shreg_pkg.sv
/*
 * Shared constants and types for the four-stage shift register and its
 * snapshot FIFO.
 * Assumes nothing of its surroundings; imported by shift_register4 and the bench.
 */
`default_nettype none

package shreg_pkg;

    // ----------------------------------------------------------------
    // Widths and depths
    // ----------------------------------------------------------------
    localparam int STAGES     = 4;
    localparam int FIFO_DEPTH = 8;
    localparam int SYNC_LEN   = 2;

    // ----------------------------------------------------------------
    // Reset and clear values
    // ----------------------------------------------------------------
    localparam logic [STAGES-1:0] STAGE_CLEAR  = 4'h0;
    localparam logic              LAST_N_CLEAR = 1'b1;

    // ----------------------------------------------------------------
    // Bit positions in the synchronised pin vector
    // ----------------------------------------------------------------
    localparam int PIN_DATA  = 0;
    localparam int PIN_KN    = 4;
    localparam int PIN_J     = 5;
    localparam int PIN_MODE  = 6;
    localparam int PIN_CLK   = 7;
    localparam int PIN_CLR_N = 8;
    localparam int PIN_COUNT = 9;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    typedef enum logic
    {
        MODE_LOAD  = 1'b0,
        MODE_SHIFT = 1'b1
    } mode_t;

endpackage : shreg_pkg

`default_nettype wire

// >>> snap_if.sv
/*
 * Valid/ready carrier between the shift register core and its FIFO.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/100ps
`default_nettype none

interface snap_if #(parameter int WIDTH = 4);
    logic             valid;
    logic             ready;
    logic [WIDTH-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : snap_if

`default_nettype wire

// >>> snap_fifo.sv
/*
 * Small synchronous FIFO with a registered output stage.
 * Assumes one clock and a synchronous active-low reset; holds DEPTH words
 * in memory plus one in the output register.
 */
`timescale 1ns/100ps
`default_nettype none

module snap_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    // Fill side
    snap_if.sink                  wr,
    // Drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
        begin : g_bad_size
            $error("snap_fifo: DEPTH must be a power of two >= 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             out_valid_reg;
    logic [WIDTH-1:0] out_data_reg;
    logic             push;
    logic             pop;

    assign wr.ready    = (count_reg != DEPTH[AW:0]);
    assign push        = wr.valid && wr.ready;
    assign pop         = (count_reg != '0) && (!out_valid_reg || out_ready_i);
    assign out_valid_o = out_valid_reg;
    assign out_data_o  = out_data_reg;

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (push)
            mem[wr_ptr_reg] <= wr.data;
    end

    // ----------------------------------------------------------------
    // Pointers and fill level
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Output register
    // ----------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            out_valid_reg <= 1'b0;
            out_data_reg  <= '0;
        end
        else if (pop)
        begin
            out_valid_reg <= 1'b1;
            out_data_reg  <= mem[rd_ptr_reg];
        end
        else if (out_ready_i)
            out_valid_reg <= 1'b0;
    end

endmodule : snap_fifo

`default_nettype wire

// >>> shift_register4.sv
/*
 * Four-stage parallel-access shift register with J/K-bar serial entry,
 * load-or-shift select and overriding active-low clear.
 * Assumes all register pins come from off-chip and are asynchronous to
 * clock_i; each applied shift-clock edge is also pushed as a snapshot into a FIFO.
 * Clear acts after the synchroniser, a few clock_i cycles after the pin.
 */
`timescale 1ns/100ps
`default_nettype none

module shift_register4
    import shreg_pkg::*;
#(
    parameter int WIDTH = shreg_pkg::STAGES,
    parameter int DEPTH = shreg_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic                           clock_i,
    input  wire logic                           nrst_i,
    // Register pins
    input  wire logic                           clear_n_i,
    input  wire logic                           shift_clk_i,
    input  wire logic                           load_or_shift_i,
    input  wire logic                           serial_j_i,
    input  wire logic                           serial_k_n_i,
    input  wire logic [shreg_pkg::STAGES-1:0]   par_data_i,
    // Parallel outputs
    output logic      [shreg_pkg::STAGES-1:0]   stage_o,
    output logic                                last_n_o,
    // Snapshot stream
    output logic                                snap_valid_o,
    input  wire logic                           snap_ready_i,
    output logic      [shreg_pkg::STAGES-1:0]   snap_data_o,
    output logic                                stalled_o
);
    import shreg_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    generate
        if (WIDTH != STAGES)
        begin : g_bad_width
            $error("shift_register4: WIDTH must equal the stage count");
        end
        if (DEPTH < 2)
        begin : g_bad_depth
            $error("shift_register4: DEPTH must be at least two");
        end
    endgenerate

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // Every pin is asynchronous to clock_i; only sync2_reg feeds logic.
    // Clear reads as asserted until the chain fills after reset, which
    // only repeats the reset values.
    logic [PIN_COUNT-1:0] pins;
    logic [PIN_COUNT-1:0] sync1_reg;
    logic [PIN_COUNT-1:0] sync2_reg;
    logic                 clk_prev_reg;

    assign pins = {clear_n_i, shift_clk_i, load_or_shift_i,
                   serial_j_i, serial_k_n_i, par_data_i};

    genvar gi;
    generate
        for (gi = 0; gi < PIN_COUNT; gi++)
        begin : g_sync
            always_ff @(posedge clock_i)
            begin
                if (!nrst_i)
                begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end
                else
                begin
                    sync1_reg[gi] <= pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Synchronised pin fields and shift-clock edge
    // ----------------------------------------------------------------
    logic              clr_n;
    logic              clk_s;
    mode_t             mode;
    logic              j_s;
    logic              kn_s;
    logic [WIDTH-1:0]  data_s;
    logic              clk_rise;

    assign clr_n    = sync2_reg[PIN_CLR_N];
    assign clk_s    = sync2_reg[PIN_CLK];
    assign mode     = mode_t'(sync2_reg[PIN_MODE]);
    assign j_s      = sync2_reg[PIN_J];
    assign kn_s     = sync2_reg[PIN_KN];
    assign data_s   = sync2_reg[PIN_DATA +: STAGES];
    assign clk_rise = clk_s && !clk_prev_reg;

    // Starts low like the idle shift-clock pin, so reset makes no false edge
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            clk_prev_reg <= 1'b0;
        else
            clk_prev_reg <= clk_s;
    end

    // ----------------------------------------------------------------
    // Edge pending until the snapshot FIFO has room
    // ----------------------------------------------------------------
    snap_if #(.WIDTH(STAGES)) snap ();

    // A rise that finds the FIFO full waits here; a further rise while one
    // waits merges with it, so every applied edge still yields one word
    logic edge_pend_reg;
    logic apply;

    assign apply = clr_n && (clk_rise || edge_pend_reg) && snap.ready;

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i || !clr_n)
            edge_pend_reg <= 1'b0;
        else if (clk_rise && !snap.ready)
            edge_pend_reg <= 1'b1;
        else if (apply)
            edge_pend_reg <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Stage update
    // ----------------------------------------------------------------
    logic [WIDTH-1:0] stage_reg;
    logic [WIDTH-1:0] stage_next;
    logic             last_n_reg;
    logic             first_next;

    always_comb
    begin
        unique case ({j_s, kn_s})
            2'b00:   first_next = 1'b0;
            2'b11:   first_next = 1'b1;
            2'b10:   first_next = ~stage_reg[0];
            2'b01:   first_next = stage_reg[0];
            default: first_next = stage_reg[0];
        endcase
    end

    // A waiting edge uses the pins as they stand when it is applied
    always_comb
    begin
        stage_next = stage_reg;
        if (!clr_n)
            stage_next = STAGE_CLEAR;
        else if (apply)
        begin
            case (mode)
                MODE_LOAD:  stage_next = data_s;
                MODE_SHIFT: stage_next = {stage_reg[WIDTH-2:0], first_next};
                default:    stage_next = stage_reg;
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            stage_reg <= STAGE_CLEAR;
        else
            stage_reg <= stage_next;
    end

    // ----------------------------------------------------------------
    // Inverted last stage
    // ----------------------------------------------------------------
    // Registered from the same next value so it never lags stage_o
    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
            last_n_reg <= LAST_N_CLEAR;
        else
            last_n_reg <= ~stage_next[WIDTH-1];
    end

    assign stage_o   = stage_reg;
    assign last_n_o  = last_n_reg;
    assign stalled_o = edge_pend_reg;

    // ----------------------------------------------------------------
    // Snapshot stream
    // ----------------------------------------------------------------
    // Each applied edge pushes the value the stages take on that edge
    assign snap.valid = apply;
    assign snap.data  = stage_next;

    snap_fifo #(
        .WIDTH(STAGES),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .nrst_i      (nrst_i),
        .wr          (snap),
        .out_valid_o (snap_valid_o),
        .out_ready_i (snap_ready_i),
        .out_data_o  (snap_data_o)
    );

endmodule : shift_register4

`default_nettype wire

// >>> shift_register4_properties.sv
/* Port-level checks of the four-stage shift register.
   Assumes pins held steady around each shift-clock edge, as the bench does. */
`timescale 1ns/100ps
`default_nettype none

module shift_register4_properties (
    input wire logic       clock_i, nrst_i, clear_n_i, shift_clk_i,
    input wire logic       load_or_shift_i, serial_j_i, serial_k_n_i,
    input wire logic [3:0] par_data_i, stage_o, snap_data_o,
    input wire logic       last_n_o, snap_valid_o, snap_ready_i, stalled_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    chk_last_compl: assert property (last_n_o == ~stage_o[3])
        else $error("inverted last output wrong");
    chk_reset_vals: assert property ($rose(nrst_i) |-> stage_o == 4'h0 && last_n_o && !snap_valid_o)
        else $error("outputs not at reset values");
    chk_clear_wins: assert property (!clear_n_i [*5] |-> stage_o == 4'h0 && last_n_o)
        else $error("clear did not empty stages");
    chk_hold_quiet: assert property (($stable(shift_clk_i) && clear_n_i && !stalled_o) [*8] |-> $stable(stage_o))
        else $error("stages moved without an edge");
    chk_shift_moves: assert property ($changed(stage_o) && load_or_shift_i && $past(load_or_shift_i, 6)
        && clear_n_i && $past(clear_n_i, 6) |-> stage_o[3:1] == $past(stage_o[2:0]))
        else $error("shift did not move toward last stage");
    chk_first_stage: assert property ($changed(stage_o) && load_or_shift_i && $past(load_or_shift_i, 6)
        && clear_n_i && $past(clear_n_i, 6) |-> stage_o[0] == (serial_j_i ? (serial_k_n_i | ~$past(stage_o[0]))
        : (serial_k_n_i & $past(stage_o[0]))))
        else $error("first stage serial result wrong");
    chk_load_data: assert property ($changed(stage_o) && !load_or_shift_i && !$past(load_or_shift_i, 6)
        && clear_n_i && $past(clear_n_i, 6) |-> stage_o == par_data_i)
        else $error("load did not take parallel data");
    chk_snap_holds: assert property (snap_valid_o && !snap_ready_i |=> snap_valid_o && $stable(snap_data_o))
        else $error("snapshot word dropped before taken");
    chk_stall_stays: assert property (stalled_o && snap_valid_o && !snap_ready_i && clear_n_i
        && $past(clear_n_i, 4) |=> stalled_o)
        else $error("stall ended with no room");
endmodule : shift_register4_properties

bind shift_register4 shift_register4_properties shift_register4_properties_i (
    .clock_i         (clock_i),
    .nrst_i          (nrst_i),
    .clear_n_i       (clear_n_i),
    .shift_clk_i     (shift_clk_i),
    .load_or_shift_i (load_or_shift_i),
    .serial_j_i      (serial_j_i),
    .serial_k_n_i    (serial_k_n_i),
    .par_data_i      (par_data_i),
    .stage_o         (stage_o),
    .snap_data_o     (snap_data_o),
    .last_n_o        (last_n_o),
    .snap_valid_o    (snap_valid_o),
    .snap_ready_i    (snap_ready_i),
    .stalled_o       (stalled_o)
);

`default_nettype wire

// >>> snap_sink.sv
/* Board-side reader of the snapshot stream; counts the words it takes.
   Assumes the same clock and reset as the design. */
`timescale 1ns/100ps
`default_nettype none

module snap_sink (
    input  wire logic        clock_i,
    input  wire logic        nrst_i,
    input  wire logic        go_i,
    input  wire logic        slow_i,
    input  wire logic        valid_i,
    output logic             ready_o,
    output logic [15:0]      taken_o
);
    logic phase_reg;

    // Slow mode takes a word only every other cycle
    assign ready_o = go_i && (!slow_i || phase_reg);

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            phase_reg <= 1'b0;
            taken_o   <= 16'h0000;
        end
        else
        begin
            phase_reg <= ~phase_reg;
            if (valid_i && ready_o)
                taken_o <= taken_o + 16'h0001;
        end
    end
endmodule : snap_sink

`default_nettype wire

// >>> testbench.sv
/* Self-checking bench for the four-stage shift register.
   Assumes the package, FIFO, design, checker and snap_sink are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; $display("unexpected %s exp %h got %h", n, e, g); end end

module testbench;
    import shreg_pkg::*;
    logic        clock_i, nrst_i, clear_n_i, shift_clk_i, load_or_shift_i, serial_j_i, serial_k_n_i;
    logic        last_n_o, snap_valid_o, snap_ready_i, stalled_o, go, slow;
    logic [3:0]  par_data_i, stage_o, snap_data_o, exp_q;
    logic [15:0] taken, edges;
    logic [31:0] rng, r;
    int          errors, checks_done;

    shift_register4 shift_register4_i (.*);
    snap_sink snap_sink_i (.clock_i, .nrst_i, .go_i(go), .slow_i(slow), .valid_i(snap_valid_o),
                           .ready_o(snap_ready_i), .taken_o(taken));

    function automatic logic [31:0] next_rand();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : next_rand

    function automatic logic [3:0] nxt(logic [3:0] q, logic m, logic j, logic kn, logic [3:0] d);
        logic f;
        f = j ? (kn | ~q[0]) : (kn & q[0]);
        return m ? {q[2:0], f} : d;
    endfunction : nxt

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cyc

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : finish_test

    task automatic settle();
        int n;
        n = 0;
        while (stage_o !== exp_q && n < 60)
        begin
            cyc(1);
            n++;
        end
        `CHK("stage", exp_q, stage_o)
        `CHK("last_n", ~exp_q[3], last_n_o)
        if (n == 60)
            finish_test();
    endtask : settle

    // Pins set, then one shift-clock pulse of four cycles high and low
    task automatic edge_op(input logic m, j, kn, input logic [3:0] d, input bit wt);
        load_or_shift_i = m;
        serial_j_i      = j;
        serial_k_n_i    = kn;
        par_data_i      = d;
        exp_q = nxt(exp_q, m, j, kn, d);
        edges++;
        cyc(4);
        shift_clk_i = 1'b1;
        cyc(4);
        shift_clk_i = 1'b0;
        cyc(4);
        if (wt)
            settle();
    endtask : edge_op

    initial
    begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial
    begin
        rng = 32'h0000_0048;
        {nrst_i, shift_clk_i, load_or_shift_i, serial_j_i, serial_k_n_i, slow} = 6'h00;
        {clear_n_i, go} = 2'h3;
        par_data_i = 4'h0;
        exp_q = 4'h0;
        edges = 16'h0000;
        errors = 0;
        checks_done = 0;
        repeat (3) @(posedge clock_i);
        #1 nrst_i = 1'b1;
        cyc(4);
        edge_op(1'b0, 1'b1, 1'b0, 4'hf, 1'b1);
        edge_op(1'b0, 1'b1, 1'b1, 4'h0, 1'b1);
        for (int i = 0; i < 40; i++)
        begin
            r = next_rand();
            slow = r[8];
            edge_op(r[9] & r[10], r[0], r[1], r[5:2], 1'b1);
        end
        $display("test load and shift done");
        for (int i = 0; i < 8; i++)
        begin
            r = next_rand();
            edge_op(1'b1, i[1], i[0], r[3:0], 1'b1);
        end
        $display("test serial codes done");
        clear_n_i = 1'b0;
        cyc(2);
        shift_clk_i = 1'b1;
        cyc(4);
        `CHK("clear stage", 4'h0, stage_o)
        `CHK("clear last_n", 1'b1, last_n_o)
        clear_n_i = 1'b1;
        cyc(4);
        shift_clk_i = 1'b0;
        exp_q = 4'h0;
        cyc(4);
        settle();
        $display("test clear done");
        edge_op(1'b0, 1'b0, 1'b0, 4'ha, 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            r = next_rand();
            {load_or_shift_i, serial_j_i, serial_k_n_i, par_data_i} = r[6:0];
            cyc(1);
        end
        `CHK("hold", exp_q, stage_o)
        $display("test hold done");
        slow = 1'b0;
        go = 1'b0;
        repeat (10) edge_op(1'b1, 1'b1, 1'b1, 4'h0, 1'b0);
        `CHK("stalled", 1'b1, stalled_o)
        `CHK("snap valid", 1'b1, snap_valid_o)
        `CHK("snap data", nxt(4'ha, 1'b1, 1'b1, 1'b1, 4'h0), snap_data_o)
        go = 1'b1;
        settle();
        for (int n = 0; n < 40 && taken !== edges; n++)
            cyc(1);
        `CHK("words", edges, taken)
        `CHK("stall end", 1'b0, stalled_o)
        $display("test full buffer done");
        finish_test();
    end
endmodule : testbench

`default_nettype wire
